// ==== ihl_defines.svh ====
// Offsets, field positions, reset values and character codes of the record loader host.
`ifndef IHL_DEFINES_SVH
`define IHL_DEFINES_SVH

// Register byte offsets on the APB slave.
`define IHL_OFF_CTRL      8'h00
`define IHL_OFF_STATUS    8'h04
`define IHL_OFF_BAUD      8'h08
`define IHL_OFF_RECORD    8'h0C
`define IHL_OFF_RXDATA    8'h10
`define IHL_OFF_DATA_LO   8'h40
`define IHL_OFF_DATA_HI   8'h7C

// Control register bits.
`define IHL_CTRL_SEND     0
`define IHL_CTRL_SYNC     1

// Status register bits.
`define IHL_STAT_BUSY     0
`define IHL_STAT_RXFLAG   1

// Reset value of the bit period in clock cycles (115200 baud at 100 MHz).
`define IHL_BAUD_RESET    16'h0364

// Characters and record fields.
`define IHL_CHAR_SYNC     8'h55
`define IHL_CHAR_MARK     8'h3A
`define IHL_ASCII_ZERO    8'h30
`define IHL_ASCII_ALPHA   8'h37
`define IHL_RECLEN        8'h40
`define IHL_TYPE_PROGRAM  8'h00
`define IHL_DATA_WORDS    16
`define IHL_IDX_FIRST_DAT 7'h04
`define IHL_IDX_LAST      7'h44
`define IHL_UART_STOP_BIT 4'h9

`endif

// ==== ihl_pkg.sv ====
// Types shared by the record loader host and its serial engine.
package ihl_pkg;

  // Frame sequencer states.
  typedef enum logic [2:0] {
    IHL_IDLE,
    IHL_SYNC,
    IHL_MARK,
    IHL_HEX_HI,
    IHL_HEX_LO
  } ihl_fsm_e;

  // Whole state of the host controller.
  typedef struct packed {
    ihl_fsm_e          fsm;
    logic [6:0]        idx;
    logic [7:0]        sum;
    logic [7:0]        cur;
    logic [15:0][31:0] data;
    logic [7:0]        rtype;
    logic [15:0]       offset;
    logic [15:0]       baud;
    logic              rx_flag;
    logic [7:0]        rx_char;
    logic [31:0]       prdata;
    logic              pslverr;
  } ihl_host_s;

  // Whole state of the serial engine.
  typedef struct packed {
    logic        tx_busy;
    logic [3:0]  tx_bit;
    logic [15:0] tx_cnt;
    logic [9:0]  tx_shift;
    logic        rx_busy;
    logic [3:0]  rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_shift;
    logic        rx_valid;
    logic [7:0]  rx_data;
  } ihl_uart_s;

endpackage : ihl_pkg

// ==== ihl_uart_if.sv ====
// Character handshake between the frame sequencer and the serial engine.
`timescale 1ns/1ps
interface ihl_uart_if;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic [15:0] divisor;

  modport ctrl (output tx_valid, output tx_data, output divisor,
                input tx_ready, input rx_valid, input rx_data);
  modport phy  (input tx_valid, input tx_data, input divisor,
                output tx_ready, output rx_valid, output rx_data);
endinterface : ihl_uart_if

// ==== ihl_uart.sv ====
// Serial engine: 8N1 transmitter and receiver with a programmable bit period.
`timescale 1ns/1ps
`include "ihl_defines.svh"
module ihl_uart
  import ihl_pkg::*;
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Sequencer side.
  ihl_uart_if.phy   link,
  // Serial pins.
  input  wire logic rxd,
  output logic      txd
);

  ihl_uart_s s_reg;
  ihl_uart_s s_next;
  logic [15:0] rx_target;

  ////////////////////////////////////////////////////////////////////////////
  // Next state. The receiver waits half a bit for the start bit so that every
  // later sample falls in the middle of a bit; a divisor below two is not usable.
  always_comb begin
    s_next          = s_reg;
    s_next.rx_valid = 1'b0;
    // Transmitter: start bit, eight data bits LSB first, one stop bit.
    if (!s_reg.tx_busy && link.tx_valid) begin
      s_next.tx_busy  = 1'b1;
      s_next.tx_bit   = 4'h0;
      s_next.tx_cnt   = 16'h0000;
      s_next.tx_shift = {1'b1, link.tx_data, 1'b0};
    end else if (s_reg.tx_busy) begin
      if (s_reg.tx_cnt == link.divisor - 16'h0001) begin
        s_next.tx_cnt   = 16'h0000;
        s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
        if (s_reg.tx_bit == `IHL_UART_STOP_BIT) begin
          s_next.tx_busy = 1'b0;
        end else begin
          s_next.tx_bit = s_reg.tx_bit + 4'h1;
        end
      end else begin
        s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
      end
    end
    // Receiver.
    rx_target = (s_reg.rx_bit == 4'h0) ? {1'b0, link.divisor[15:1]} : link.divisor - 16'h0001;
    if (!s_reg.rx_busy) begin
      if (!rxd) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_bit  = 4'h0;
        s_next.rx_cnt  = 16'h0000;
      end
    end else if (s_reg.rx_cnt == rx_target) begin
      s_next.rx_cnt = 16'h0000;
      if (s_reg.rx_bit == 4'h0) begin
        // A start bit that is gone at mid-bit was a glitch.
        s_next.rx_busy = !rxd;
        s_next.rx_bit  = 4'h1;
      end else if (s_reg.rx_bit != `IHL_UART_STOP_BIT) begin
        s_next.rx_shift = {rxd, s_reg.rx_shift[7:1]};
        s_next.rx_bit   = s_reg.rx_bit + 4'h1;
      end else begin
        // A character without a valid stop bit is dropped.
        s_next.rx_busy  = 1'b0;
        s_next.rx_valid = rxd;
        if (rxd) begin
          s_next.rx_data = s_reg.rx_shift;
        end
      end
    end else begin
      s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{tx_shift: 10'h3FF, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs.
  assign txd           = s_reg.tx_shift[0];
  assign link.tx_ready = !s_reg.tx_busy;
  assign link.rx_valid = s_reg.rx_valid;
  assign link.rx_data  = s_reg.rx_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_reg.tx_busy && link.tx_valid) |=> !txd)
    else $error("start bit not driven low");
  a_stop_bit_high: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.tx_busy && s_reg.tx_bit == `IHL_UART_STOP_BIT) |-> txd)
    else $error("stop bit not high");

endmodule : ihl_uart

// ==== ihl_isp_host.sv ====
// Host controller that sends hex records and the baud sync character to the loader.
`timescale 1ns/1ps
`include "ihl_defines.svh"
module ihl_isp_host
  import ihl_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link to the loader.
  output logic             uart_txd,
  input  wire logic        uart_rxd,
  // Frame in progress.
  output logic             busy
);

  ihl_host_s r_reg;
  ihl_host_s r_next;
  ihl_uart_if link ();

  localparam ihl_host_s HOST_RST = '{fsm: IHL_IDLE, baud: `IHL_BAUD_RESET, default: '0};

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Converts a nibble to its upper-case ASCII hex digit.
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    logic [7:0] wide;
    wide = {4'h0, nib};
    if (nib < 4'hA) begin
      return `IHL_ASCII_ZERO + wide;
    end else begin
      return `IHL_ASCII_ALPHA + wide;
    end
  endfunction : hex_char

  // Picks the binary byte at frame position idx; sum is the running total so far.
  function automatic logic [7:0] frame_byte(input ihl_host_s s, input logic [6:0] idx,
                                            input logic [7:0] sum);
    logic [6:0] j;
    logic       use_off;
    j       = idx - `IHL_IDX_FIRST_DAT;
    use_off = (s.rtype == `IHL_TYPE_PROGRAM);
    unique case (idx)
      7'h00:       return `IHL_RECLEN;
      7'h01:       return use_off ? s.offset[15:8] : 8'h00;
      7'h02:       return use_off ? s.offset[7:0] : 8'h00;
      7'h03:       return s.rtype;
      `IHL_IDX_LAST: return 8'h00 - sum;
      default:     return s.data[j[5:2]][{j[1:0], 3'b000} +: 8];
    endcase
  endfunction : frame_byte

  logic acc;
  logic setup_rd;
  logic mapped;
  logic in_data;
  logic [3:0] word_idx;
  logic [7:0] next_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: the data window is sixteen aligned words.
  always_comb begin
    in_data  = (paddr >= `IHL_OFF_DATA_LO) && (paddr <= `IHL_OFF_DATA_HI) && (paddr[1:0] == 2'b00);
    word_idx = paddr[5:2];
    mapped   = in_data || (paddr == `IHL_OFF_CTRL) || (paddr == `IHL_OFF_STATUS) ||
               (paddr == `IHL_OFF_BAUD) || (paddr == `IHL_OFF_RECORD) || (paddr == `IHL_OFF_RXDATA);
  end

  assign acc      = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign next_sum = r_reg.sum + r_reg.cur;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register file, frame sequencer and reply capture.
  always_comb begin
    r_next = r_reg;

    // Read data and error are prepared in the setup cycle so they come from flops.
    if (psel && !penable) begin
      r_next.pslverr = !mapped;
      r_next.prdata  = 32'h0000_0000;
      if (setup_rd && mapped) begin
        if (in_data) begin
          r_next.prdata = r_reg.data[word_idx];
        end else if (paddr == `IHL_OFF_STATUS) begin
          r_next.prdata = {16'h0000, r_reg.rx_char, 6'h00, r_reg.rx_flag, r_reg.fsm != IHL_IDLE};
        end else if (paddr == `IHL_OFF_BAUD) begin
          r_next.prdata = {16'h0000, r_reg.baud};
        end else if (paddr == `IHL_OFF_RECORD) begin
          r_next.prdata = {8'h00, r_reg.offset, r_reg.rtype};
        end else if (paddr == `IHL_OFF_RXDATA) begin
          r_next.prdata = {24'h000000, r_reg.rx_char};
        end
      end
    end

    // Reading the reply clears its flag; a reply landing in the same cycle wins below.
    if (acc && !pwrite && paddr == `IHL_OFF_RXDATA) begin
      r_next.rx_flag = 1'b0;
    end

    // Writes take effect in the access cycle. Frame contents are frozen while a
    // frame is on the wire, so a late write cannot corrupt the checksum.
    if (acc && pwrite && mapped && r_reg.fsm == IHL_IDLE) begin
      if (in_data) begin
        r_next.data[word_idx] = pwdata;
      end else if (paddr == `IHL_OFF_BAUD) begin
        r_next.baud = (pwdata[15:0] < 16'h0002) ? 16'h0002 : pwdata[15:0];
      end else if (paddr == `IHL_OFF_RECORD) begin
        r_next.rtype  = pwdata[7:0];
        r_next.offset = pwdata[23:8];
      end else if (paddr == `IHL_OFF_CTRL) begin
        if (pwdata[`IHL_CTRL_SYNC]) begin
          r_next.fsm = IHL_SYNC;
        end else if (pwdata[`IHL_CTRL_SEND]) begin
          r_next.fsm = IHL_MARK;
        end
      end
    end

    // Frame sequencer: advances each time the serial engine takes a character.
    unique case (r_reg.fsm)
      IHL_IDLE: begin
      end
      IHL_SYNC: begin
        if (link.tx_ready) begin
          r_next.fsm = IHL_IDLE;
        end
      end
      IHL_MARK: begin
        if (link.tx_ready) begin
          r_next.fsm = IHL_HEX_HI;
          r_next.idx = 7'h00;
          r_next.sum = 8'h00;
          r_next.cur = frame_byte(r_reg, 7'h00, 8'h00);
        end
      end
      IHL_HEX_HI: begin
        if (link.tx_ready) begin
          r_next.fsm = IHL_HEX_LO;
        end
      end
      IHL_HEX_LO: begin
        if (link.tx_ready) begin
          r_next.sum = next_sum;
          if (r_reg.idx == `IHL_IDX_LAST) begin
            r_next.fsm = IHL_IDLE;
          end else begin
            r_next.fsm = IHL_HEX_HI;
            r_next.idx = r_reg.idx + 7'h01;
            r_next.cur = frame_byte(r_reg, r_reg.idx + 7'h01, next_sum);
          end
        end
      end
    endcase

    // Capture each reply character (X, Y, Z, CR, LF or read data).
    if (link.rx_valid) begin
      r_next.rx_flag = 1'b1;
      r_next.rx_char = link.rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= HOST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character offered to the serial engine.
  always_comb begin
    link.tx_valid = (r_reg.fsm != IHL_IDLE);
    link.divisor  = r_reg.baud;
    unique case (r_reg.fsm)
      IHL_SYNC:   link.tx_data = `IHL_CHAR_SYNC;
      IHL_MARK:   link.tx_data = `IHL_CHAR_MARK;
      IHL_HEX_HI: link.tx_data = hex_char(r_reg.cur[7:4]);
      IHL_HEX_LO: link.tx_data = hex_char(r_reg.cur[3:0]);
      default:    link.tx_data = 8'h00;
    endcase
  end

  // Serial engine.
  ihl_uart u_uart (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (link),
    .rxd     (uart_rxd),
    .txd     (uart_txd)
  );

  // Bus and status outputs.
  assign prdata  = r_reg.prdata;
  assign pslverr = r_reg.pslverr && acc;
  assign pready  = acc;
  assign busy    = (r_reg.fsm != IHL_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_sync_char: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_SYNC) |-> (link.tx_valid && link.tx_data == 8'h55))
    else $error("sync character is not U");
  a_frame_mark: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_MARK && link.tx_ready) |=> (r_reg.fsm == IHL_HEX_HI && r_reg.idx == 7'h00))
    else $error("colon not followed by length byte");
  a_length_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.idx == 7'h00) |-> (r_reg.cur == 8'h40))
    else $error("length byte is not 40h");
  a_frame_end: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(r_reg.fsm) == IHL_HEX_LO && r_reg.fsm == IHL_IDLE) |-> ($past(r_reg.idx) == 7'h44))
    else $error("frame ended at wrong byte count");
  a_hex_digit: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI || r_reg.fsm == IHL_HEX_LO) |->
      ((link.tx_data >= 8'h30 && link.tx_data <= 8'h39) || (link.tx_data >= 8'h41 && link.tx_data <= 8'h46)))
    else $error("character is not a hex digit");
  a_hex_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && link.tx_ready) |=> (r_reg.fsm == IHL_HEX_LO) ##0 $stable(r_reg.cur))
    else $error("hex pair split");
  a_offset_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.rtype != 8'h00 && (r_reg.idx == 7'h01 || r_reg.idx == 7'h02))
      |-> (r_reg.cur == 8'h00))
    else $error("unused offset not zero");
  a_checksum_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.idx == 7'h44) |-> (8'(r_reg.sum + r_reg.cur) == 8'h00))
    else $error("record sum not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and register checks.
  // The colon is offered whenever the sequencer sits in the mark state.
  a_mark_char: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_MARK) |-> (link.tx_valid && link.tx_data == 8'h3A))
    else $error("frame mark is not a colon");
  // A send order on an idle block starts a frame with its mark.
  a_send_starts: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && paddr == `IHL_OFF_CTRL && pwdata[1:0] == 2'b01 && !busy) |=> (r_reg.fsm == IHL_MARK))
    else $error("send order did not start a frame");
  // A sync order wins over a send order written in the same word.
  a_sync_starts: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && paddr == `IHL_OFF_CTRL && pwdata[1] && !busy) |=> (r_reg.fsm == IHL_SYNC))
    else $error("sync order did not start");
  // The sync character is a single character and nothing follows it.
  a_sync_single: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_SYNC && link.tx_ready) |=> (r_reg.fsm == IHL_IDLE))
    else $error("sync not a single character");
  // A divisor below two would leave the receiver's half-bit wait at zero.
  a_divisor_baud: assert property (@(posedge pclk) disable iff (!presetn)
    (link.divisor == r_reg.baud) && (r_reg.baud >= 16'h0002))
    else $error("bit period out of range");
  // The byte index never runs past the checksum.
  a_idx_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI || r_reg.fsm == IHL_HEX_LO) |-> (r_reg.idx <= 7'h44))
    else $error("byte index past checksum");
  // Each finished byte moves the index by exactly one.
  a_idx_step: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_LO && link.tx_ready && r_reg.idx != 7'h44) |=> (r_reg.idx == 7'($past(r_reg.idx) + 7'h01)))
    else $error("byte index skipped");
  // The running sum takes in every byte once.
  a_sum_step: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_LO && link.tx_ready && r_reg.idx != 7'h44) |=> (r_reg.sum == 8'($past(r_reg.sum) + $past(r_reg.cur))))
    else $error("running sum wrong");
  // Program records carry the load offset, high byte first.
  a_offset_high: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.rtype == 8'h00 && r_reg.idx == 7'h01) |-> (r_reg.cur == r_reg.offset[15:8]))
    else $error("offset high byte wrong");
  a_offset_low: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.rtype == 8'h00 && r_reg.idx == 7'h02) |-> (r_reg.cur == r_reg.offset[7:0]))
    else $error("offset low byte wrong");
  // The type byte follows the offset.
  a_type_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && r_reg.idx == 7'h03) |-> (r_reg.cur == r_reg.rtype))
    else $error("type byte wrong");
  // Writes during a frame must not disturb what the checksum covers.
  a_frame_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && busy) |=> ($stable(r_reg.data) && $stable(r_reg.rtype) && $stable(r_reg.offset)))
    else $error("frame contents changed while busy");
  // A received reply is kept and flagged.
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    link.rx_valid |=> (r_reg.rx_flag && r_reg.rx_char == $past(link.rx_data)))
    else $error("reply not captured");
  // Reading the reply clears its flag when no new reply lands.
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == `IHL_OFF_RXDATA && !link.rx_valid) |=> !r_reg.rx_flag)
    else $error("reply flag not cleared");
  // The checksum is the last character of a frame.
  a_frame_done: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_LO && link.tx_ready && r_reg.idx == 7'h44) |=> !busy)
    else $error("frame did not end after checksum");
  // Nothing is offered to the engine while idle.
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_IDLE) |-> !link.tx_valid)
    else $error("character offered while idle");
  // A digit waits, unchanged, until the engine takes it.
  a_hold_high: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_HI && !link.tx_ready) |=> (r_reg.fsm == IHL_HEX_HI && $stable(r_reg.cur)))
    else $error("high digit dropped");
  a_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.fsm == IHL_HEX_LO && !link.tx_ready) |=> (r_reg.fsm == IHL_HEX_LO && $stable(r_reg.idx)))
    else $error("low digit dropped");

endmodule : ihl_isp_host

// ==== ihl_loader_model.sv ====
// Behavioural loader on the far side of the serial link: baud detection, record parsing and replies.
`timescale 1ns/1ps
module ihl_loader_model #(
  parameter logic [7:0] VERSION = 8'h2A  // Arbitrary loader version value.
) (
  // Clock.
  input  wire logic        pclk,
  // Serial lines, idle high.
  input  wire logic        rxd,
  output logic             txd,
  // Observations for the bench.
  output logic             sync_stb,
  output logic [15:0]      bit_cyc,
  output logic             frm_stb,
  output logic [40:0]      frm_sum
);
  logic [7:0] ch;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [7:0] rep;
  logic [7:0] sum;
  logic [7:0] dsum;
  logic [7:0] sec_byte;
  logic [7:0] b [0:68];
  logic [4:0] vh;
  logic [4:0] vl;
  logic       bad;

  ////////////////////////////////////////////////////////////////////////////////
  // Digit value; bit 4 marks a character that is not an upper-case hex digit.
  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
    if (c >= 8'h41 && c <= 8'h46) return {1'b0, c[3:0] + 4'h9};
    return 5'h10;
  endfunction : hexval

  // Mid-bit sampling on falling edges keeps clear of the host's launch edge.
  task automatic get_char(output logic [7:0] c);
    while (rxd !== 1'b0) @(negedge pclk);
    repeat (bit_cyc / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge pclk);
      c[i] = rxd;
    end
    repeat (bit_cyc) @(negedge pclk);
    if (rxd !== 1'b1) bad = 1'b1;
  endtask : get_char

  // One character, start bit first, at the measured period.
  task automatic put_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd = f[i];
      repeat (bit_cyc) @(negedge pclk);
    end
  endtask : put_char

  ////////////////////////////////////////////////////////////////////////////////
  // The start bit of the sync character sets the period; records are then served forever.
  initial begin
    txd = 1'b1;
    sync_stb = 1'b0;
    frm_stb = 1'b0;
    bit_cyc = 16'h0000;
    frm_sum = '0;
    sec_byte = 8'hFF;
    @(negedge pclk);
    while (rxd !== 1'b0) @(negedge pclk);
    while (rxd === 1'b0) begin
      bit_cyc = bit_cyc + 16'h0001;
      @(negedge pclk);
    end
    repeat (8 * bit_cyc + bit_cyc / 2) @(negedge pclk);
    sync_stb = 1'b1;
    @(negedge pclk);
    sync_stb = 1'b0;
    forever begin
      bad = 1'b0;
      sum = 8'h00;
      dsum = 8'h00;
      do get_char(ch); while (ch !== 8'h3A);
      for (int n = 0; n < 69; n++) begin
        get_char(hi);
        get_char(lo);
        vh = hexval(hi);
        vl = hexval(lo);
        bad = bad | vh[4] | vl[4];
        b[n] = {vh[3:0], vl[3:0]};
        sum = sum + b[n];
        if (n >= 4 && n < 68) dsum = dsum + b[n];
      end
      bad = bad | (sum != 8'h00) | (b[0] != 8'h40);
      frm_sum = {b[0], b[3], b[1], b[2], dsum, ~bad};
      frm_stb = 1'b1;
      @(negedge pclk);
      frm_stb = 1'b0;
      if (bad) rep = 8'h58;
      else if (b[3] == 8'h05) rep = (b[4] == 8'h07) ? sec_byte : VERSION;
      else begin
        if (b[3] == 8'h03 && b[4] == 8'h07 && b[5] == 8'h00) sec_byte = 8'hFF;
        rep = 8'h59;
      end
      put_char(rep);
    end
  end
endmodule : ihl_loader_model

// ==== tb.sv ====
// Self-checking bench for the record loader host facing a behavioural loader.
`timescale 1ns/1ps
`include "ihl_defines.svh"
module tb;
  localparam logic [7:0] VER = 8'h2A;  // Arbitrary loader version value.
  localparam int         BIT = 4;      // Short bit period keeps a record near six thousand cycles.

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        uart_txd;
  logic        uart_rxd;
  logic        busy;
  logic        sync_stb;
  logic        frm_stb;
  logic [15:0] bit_cyc;
  logic [40:0] frm_sum;
  logic [32:0] rdq [$];
  logic [40:0] frq [$];
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and loader model.
  ihl_isp_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart_txd(uart_txd), .uart_rxd(uart_rxd), .busy(busy));
  ihl_loader_model #(.VERSION(VER)) loader (.pclk(pclk), .rxd(uart_txd), .txd(uart_rxd),
    .sync_stb(sync_stb), .bit_cyc(bit_cyc), .frm_stb(frm_stb), .frm_sum(frm_sum));

  // Clock of 10 ns period.
  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value against its expectation and count the outcome.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print the verdict and stop.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // One APB transfer; the bus idles a cycle after it so no signal is driven twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read with the expected error flag and data noted first.
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rdq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Load and send one record, then check the frame seen by the loader and its reply.
  task automatic send_rec(input logic [7:0] t, input logic [15:0] d01, input logic [7:0] rep);
    logic [31:0] w;
    logic [31:0] rec;
    logic [7:0]  ds;
    rec = {8'h00, 16'($urandom), t};
    ds = 8'h00;
    for (int k = 0; k < 16; k++) begin
      w = $urandom;
      if (k == 0) w[15:0] = {d01[7:0], d01[15:8]};
      ds = ds + w[7:0] + w[15:8] + w[23:16] + w[31:24];
      apb(1'b1, `IHL_OFF_DATA_LO + 8'(4 * k), w);
    end
    apb(1'b1, `IHL_OFF_RECORD, rec);
    frq.push_back({8'h40, t, (t == 8'h00) ? rec[23:8] : 16'h0000, ds, 1'b1});
    apb(1'b1, `IHL_OFF_CTRL, 32'h1);
    check(busy, 1'b1);
    apb(1'b1, `IHL_OFF_RECORD, ~rec);
    for (int i = 0; i < 20000 && frm_stb !== 1'b1; i++) @(posedge pclk);
    repeat (60) @(posedge pclk);
    rd(`IHL_OFF_STATUS, {17'h0, rep, 8'h02});
    rd(`IHL_OFF_RXDATA, {25'h0, rep});
    rd(`IHL_OFF_STATUS, {17'h0, rep, 8'h00});
    rd(`IHL_OFF_RECORD, {1'b0, rec});
  endtask : send_rec

  ////////////////////////////////////////////////////////////////////////////////
  // Read results and loader frames are matched against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, rdq.pop_front());
    if (frm_stb === 1'b1) check(frm_sum, frq.pop_front());
  end

  // A hang is cut short well beyond the expected run of about forty-one thousand cycles.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      conclude();
    end
  end

  // Main sequence: reset values, baud register, sync character, then records of types 00, 03, 01, 04, 05, 05 and 06.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h223EBE5C));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`IHL_OFF_BAUD, {17'h0, `IHL_BAUD_RESET});
    rd(`IHL_OFF_STATUS, 33'h0);
    rd(`IHL_OFF_RECORD, 33'h0);
    rd(`IHL_OFF_DATA_HI, 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    apb(1'b1, `IHL_OFF_BAUD, 32'h1);
    rd(`IHL_OFF_BAUD, 33'h2);
    apb(1'b1, `IHL_OFF_BAUD, 32'(BIT));
    apb(1'b1, `IHL_OFF_CTRL, 32'h3);
    for (int i = 0; i < 200 && sync_stb !== 1'b1; i++) @(posedge pclk);
    check(bit_cyc, BIT);
    repeat (60) @(posedge pclk);
    send_rec(8'h00, 16'($urandom), 8'h59);
    send_rec(8'h03, 16'h0700, 8'h59);
    send_rec(8'h01, 16'h0000, 8'h59);
    send_rec(8'h04, 16'h0000, 8'h59);
    send_rec(8'h05, 16'h0700, 8'hFF);
    send_rec(8'h05, 16'h0F00, VER);
    send_rec(8'h06, 16'h0000, 8'h59);
    conclude();
  end
endmodule : tb
